// *** pkg/srsc_pkg.sv ***
// Constants for the service-request and status control block.
// Assumes a 20 MHz core clock and a 32-bit classic Wishbone slave port.
// Contract
// RL1 - Fault query read clears that fault register
// RL2 - Serial poll clears request bit, keeps faults
// RL3 - Request enable 0..3, query returns value
// RL4 - Enable 0 never blocks power-on request
// RL5 - Power-up enable 1 requests at switch-on
// RL6 - Power-up enable kept in non-volatile store
// RL7 - Request bit set by error, fault, power-on
// RL8 - Delay blocks regulation bits from fault logic
// RL9 - Setpoint style commands restart channel delay
// RL10 - Delay value starts at 20 ms
// RL11 - Delay 0..32 s, rounded to 4 ms
// RL12 - Delay out of range is programming error
// RL13 - Display on with 1, off with 0
// RL14 - Message twelve chars, restricted set, else error; code turns other characters into spaces
// RL15 - Error sets flag; error query clears it
// RL16 - Self-test any time, code returned
// RL17 - Calibration query returns 1 or 0
// RL18 - Power-up output state 0/1, off in CV
// RL19 - Power-up output state 2/3, off in CC
// RL20 - Model query returns identification
// RL21 - Request bit is weight 64 of poll byte
// RL22 - Any fault bit sets channel trouble flag
// RL23 - Per-channel 4 ms delay counter to zero
package srsc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_POLL  = 8'h04;
   localparam logic [7:0] OFS_ERR   = 8'h08;
   localparam logic [7:0] OFS_TEST  = 8'h0c;
   localparam logic [7:0] OFS_INFO  = 8'h10;
   localparam logic [7:0] OFS_MODEL = 8'h14;
   localparam logic [7:0] OFS_CMD   = 8'h18;
   localparam logic [7:0] OFS_MLEN  = 8'h1c;
   localparam logic [7:0] OFS_FAULT = 8'h20;
   localparam logic [7:0] OFS_MASK  = 8'h30;
   localparam logic [7:0] OFS_DLY   = 8'h40;
   localparam logic [7:0] OFS_MSG   = 8'h50;
   // Control register fields
   localparam int CTRL_SRQ_LSB = 0;
   localparam int CTRL_PON     = 2;
   localparam int CTRL_DISP    = 3;
   localparam int CTRL_PUS_LSB = 4;
   // Command register fields
   localparam int CMD_CLR      = 4;
   // Serial poll bit positions
   localparam int POLL_RDY = 4;
   localparam int POLL_ERR = 5;
   localparam int POLL_RQS = 6;
   localparam int POLL_PON = 7;
   // Status bits that the reprogramming delay hides
   localparam logic [7:0] STAT_GATED = 8'h47;
   // Error and test codes
   localparam logic [4:0] EC_NONE  = 5'h00;
   localparam logic [4:0] EC_RANGE = 5'h05;
   localparam logic [4:0] EC_LEN   = 5'h07;
   localparam logic [4:0] EC_HW    = 5'h0a;
   localparam logic [4:0] TC_TIMER = 5'h14;
   // Delay timing
   localparam int DLY_STEP_NS   = 4_000_000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int DLY_TICK_CYC  = DLY_STEP_NS / CLK_PERIOD_NS;
   localparam int DLY_INIT_MS   = 20;
   localparam int DLY_STEP_MS   = 4;
   localparam int DLY_MAX_MS    = 32_000;
   localparam int DLY_W         = 14;
   localparam logic [DLY_W-1:0] DLY_INIT =
      DLY_W'(DLY_INIT_MS / DLY_STEP_MS);
   localparam logic [15:0] DLY_MAX = 16'(DLY_MAX_MS);
   // Message
   localparam int MSG_CHARS = 12;
   localparam logic [7:0] CH_SPACE = 8'h20;
   // Power-up output state values
   localparam logic [1:0] PUS_ON_CV  = 2'h1;
   localparam logic [1:0] PUS_ON_CC  = 2'h2;
   localparam logic [1:0] PUS_OFF_CC = 2'h3;
   localparam logic [1:0] PUS_RESET  = 2'h0;
endpackage

// *** rtl/srsc_sync.sv ***
// Two-stage synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level; no bus coherence is implied.
`timescale 1ns/1ps
module srsc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         reset_n_i,
   // Levels
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);
   logic [W-1:0] meta_q;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule

// *** rtl/srsc_dly_chan.sv ***
// One channel's reprogramming delay counter in 4 ms units.
// Assumes tick_i is a single-cycle pulse once per delay step.
`timescale 1ns/1ps
module srsc_dly_chan
   import srsc_pkg::*;
(
   // Clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             reset_n_i,
   // Control
   input  wire logic             tick_i,
   input  wire logic             restart_i,
   input  wire logic [DLY_W-1:0] reload_i,
   // State
   output logic                  busy_o
);
   logic [DLY_W-1:0] cnt_q;

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q <= '0;
      end else if (restart_i) begin
         cnt_q <= reload_i; // [RL9] [RL23]
      end else if (tick_i && cnt_q != '0) begin
         cnt_q <= cnt_q - DLY_W'(1); // [RL23]
      end
   end

   assign busy_o = (cnt_q != '0);
endmodule

// *** rtl/srsc_top.sv ***
// Service-request, status and front-panel control behind Wishbone.
// Assumes channel status, power-fail, calibration and hardware-error
// pins are asynchronous; the non-volatile power-up bit is a strap.
`timescale 1ns/1ps
module srsc_top
   import srsc_pkg::*;
#(
   parameter int          NCH       = 4,
   parameter int          TICK_CYC  = DLY_TICK_CYC,
   parameter logic [31:0] MODEL_ID  = 32'h0000_1234 // Arbitrary value
) (
   // Clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             reset_n_i,
   // Wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [7:0]       wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // Channel status pins, eight bits per channel
   input  wire logic [8*NCH-1:0] status_i,
   output logic      [8*NCH-1:0] ocp_status_o,
   // Supply and strap pins
   input  wire logic             power_fail_i,
   input  wire logic             nv_pon_i,
   input  wire logic             cal_mode_i,
   input  wire logic             hw_err_i,
   // Non-volatile store write
   output logic                  nv_wr_o,
   output logic                  nv_data_o,
   // Request and panel
   output logic                  srq_o,
   output logic                  err_led_o,
   output logic                  disp_on_o,
   output logic [8*MSG_CHARS-1:0] disp_msg_o,
   output logic                  out_en_o,
   output logic                  off_cc_o
);
   localparam int TW = $clog2(TICK_CYC + 1);
   // Keeps only upper-case letters, digits and space
   function automatic logic [7:0] filt_char(input logic [7:0] c);
      if ((c >= 8'h41 && c <= 8'h5a) || (c >= 8'h30 && c <= 8'h39))
         filt_char = c;
      else
         filt_char = CH_SPACE;
   endfunction
   // Rounds milliseconds to the nearest 4 ms step
   function automatic logic [DLY_W-1:0] ms_to_steps(input logic [15:0] ms);
      logic [16:0] sum;
      sum = {1'b0, ms} + 17'(DLY_STEP_MS / 2);
      ms_to_steps = sum[DLY_W+1:2];
   endfunction
   // Synchronised pins
   logic [8*NCH-1:0] stat_s;
   logic             pfail_s;
   logic             cal_s;
   logic             hwerr_s;
   srsc_sync #(.W(8*NCH + 3)) u_sync (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .async_i    ({status_i, power_fail_i, cal_mode_i, hw_err_i}),
      .sync_o     ({stat_s, pfail_s, cal_s, hwerr_s})
   );
   // Bus access decode: effects happen on the acknowledging edge
   logic       req;
   logic       acc;
   logic       wr;
   logic       rd;
   logic [7:0] adr;
   logic       full;
   assign req  = wb_cyc_i & wb_stb_i;
   assign acc  = req & wb_ack_o;
   assign wr   = acc & wb_we_i;
   assign rd   = acc & ~wb_we_i;
   assign adr  = {wb_adr_i[7:2], 2'b00};
   assign full = &wb_sel_i;
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b,
                                input int n);
      hit = (a >= b) && (a < b + 8'(4 * n));
   endfunction
   logic [1:0] chf;
   assign chf = adr[3:2];
   // Control state
   logic [1:0] srq_en_q;
   logic       pon_en_q;
   logic       pon_load_q;
   logic [1:0] pus_q;
   logic       pon_bit_q;
   logic       pfail_d_q;
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         srq_en_q <= 2'h0;
         pus_q    <= PUS_RESET;
         disp_on_o <= 1'b1;
      end else if (wr && adr == OFS_CTRL && wb_sel_i[0]) begin
         srq_en_q  <= wb_dat_i[CTRL_SRQ_LSB +: 2]; // [RL3]
         disp_on_o <= wb_dat_i[CTRL_DISP]; // [RL13]
         pus_q     <= wb_dat_i[CTRL_PUS_LSB +: 2];
      end
   end
   // Power-up request enable lives in the non-volatile store
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pon_load_q <= 1'b1;
         pon_en_q   <= 1'b0;
         nv_wr_o    <= 1'b0;
         nv_data_o  <= 1'b0;
      end else begin
         pon_load_q <= 1'b0;
         nv_wr_o    <= 1'b0;
         if (pon_load_q) begin
            pon_en_q  <= nv_pon_i; // [RL6]
            nv_data_o <= nv_pon_i;
         end else if (wr && adr == OFS_CTRL && wb_sel_i[0]) begin
            pon_en_q  <= wb_dat_i[CTRL_PON];
            nv_data_o <= wb_dat_i[CTRL_PON]; // [RL6]
            nv_wr_o   <= 1'b1;
         end
      end
   end
   // Power-on event: after reset release and when the power-fail pin clears
   logic pon_evt;
   logic pon_first_q;
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pon_first_q <= 1'b1;
         pfail_d_q   <= 1'b0;
      end else begin
         pfail_d_q <= pfail_s;
         if (!pon_load_q)
            pon_first_q <= 1'b0;
      end
   end
   assign pon_evt = (pon_first_q & ~pon_load_q) | (pfail_d_q & ~pfail_s);
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         pon_bit_q <= 1'b0;
      else if (pon_evt)
         pon_bit_q <= 1'b1;
      else if (wr && adr == OFS_CMD && wb_dat_i[CMD_CLR])
         pon_bit_q <= 1'b0;
   end
   // Delay step tick and per-channel delay counters
   logic [TW-1:0]    presc_q;
   logic [TW-1:0]    presc_last_q;
   logic             tick;
   logic [NCH-1:0]   restart;
   logic [NCH-1:0]   dly_busy;
   logic [DLY_W-1:0] dly_q [NCH];
   assign tick = (presc_q == TW'(TICK_CYC - 1));
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         presc_q      <= '0;
         presc_last_q <= '0;
      end else begin
         presc_q      <= tick ? '0 : presc_q + TW'(1);
         presc_last_q <= presc_q;
      end
   end
   // Command write restarts the delay of each channel whose bit is set
   assign restart = (wr && adr == OFS_CMD) ? wb_dat_i[NCH-1:0] : '0;
   // Delay setting writes in milliseconds
   logic dly_wr;
   logic dly_bad;
   assign dly_wr  = wr && hit(adr, OFS_DLY, NCH) && full;
   assign dly_bad = dly_wr && (wb_dat_i[31:16] != 16'h0 ||
                               wb_dat_i[15:0] > DLY_MAX); // [RL12]
   // Message writes
   logic msg_wr;
   logic len_wr;
   logic len_bad;
   assign msg_wr  = wr && hit(adr, OFS_MSG, MSG_CHARS / 4) && full;
   assign len_wr  = wr && adr == OFS_MLEN;
   assign len_bad = len_wr && (wb_dat_i > 32'(MSG_CHARS)); // [RL14]

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         disp_msg_o <= {MSG_CHARS{CH_SPACE}};
      end else if (msg_wr) begin
         for (int b = 0; b < 4; b++)
            disp_msg_o[32*chf + 8*b +: 8] <=
               filt_char(wb_dat_i[8*b +: 8]); // [RL14]
      end
   end
   // Error flag with its code
   logic       hwerr_d_q;
   logic       err_evt;
   logic [4:0] err_code;
   logic [4:0] err_code_q;

   always_comb begin
      err_evt  = 1'b1;
      err_code = EC_NONE;
      if (dly_bad)
         err_code = EC_RANGE;
      else if (len_bad)
         err_code = EC_LEN;
      else if (hwerr_s & ~hwerr_d_q)
         err_code = EC_HW;
      else
         err_evt = 1'b0;
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hwerr_d_q  <= 1'b0;
         err_led_o  <= 1'b0;
         err_code_q <= EC_NONE;
      end else begin
         hwerr_d_q <= hwerr_s;
         if (err_evt) begin
            err_led_o  <= 1'b1; // [RL15]
            err_code_q <= err_code;
         end else if (rd && adr == OFS_ERR) begin
            err_led_o  <= 1'b0; // [RL15]
            err_code_q <= EC_NONE;
         end
      end
   end
   // Per-channel delay, mask and fault registers
   logic [7:0]     mask_q  [NCH];
   logic [7:0]     fault_q [NCH];
   logic [7:0]     live_q  [NCH];
   logic [NCH-1:0] trouble;
   logic [NCH-1:0] new_fault;
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic [7:0] eff;
      logic [7:0] live;
      logic [7:0] rise;
      logic       sel;
      assign sel  = (chf == 2'(c));
      // Regulation bits are held back while the delay runs
      assign eff  = dly_busy[c] ? (stat_s[8*c +: 8] & ~STAT_GATED)
                                : stat_s[8*c +: 8]; // [RL8]
      assign live = eff & mask_q[c];
      assign rise = live & ~live_q[c];
      assign new_fault[c] = |rise;
      assign trouble[c]   = |fault_q[c]; // [RL22]
      srsc_dly_chan u_dly (
         .core_clk_i (core_clk_i),
         .reset_n_i  (reset_n_i),
         .tick_i     (tick),
         .restart_i  (restart[c]),
         .reload_i   (dly_q[c]),
         .busy_o     (dly_busy[c])
      );

      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
         if (!reset_n_i)
            dly_q[c] <= DLY_INIT; // [RL10]
         else if (dly_wr && !dly_bad && sel)
            dly_q[c] <= ms_to_steps(wb_dat_i[15:0]); // [RL11]
      end

      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
         if (!reset_n_i)
            mask_q[c] <= 8'h00;
         else if (wr && hit(adr, OFS_MASK, NCH) && sel && wb_sel_i[0])
            mask_q[c] <= wb_dat_i[7:0];
      end

      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
         if (!reset_n_i)
            ocp_status_o[8*c +: 8] <= 8'h00;
         else
            ocp_status_o[8*c +: 8] <= eff; // [RL8]
      end
      // A new fault wins over the clearing read in the same cycle
      always_ff @(posedge core_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            live_q[c]  <= 8'h00;
            fault_q[c] <= 8'h00;
         end else begin
            live_q[c] <= live;
            if (rd && hit(adr, OFS_FAULT, NCH) && sel)
               fault_q[c] <= rise; // [RL1]
            else
               fault_q[c] <= fault_q[c] | rise;
         end
      end
   end
   // Request-service bit
   logic poll_rd;
   logic rqs_set;
   assign poll_rd = rd && adr == OFS_POLL;
   assign rqs_set = (err_evt && srq_en_q[1]) ||
                    (|new_fault && srq_en_q[0]) || // [RL7]
                    (pon_evt && pon_en_q); // [RL4] [RL5]
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         srq_o <= 1'b0;
      else if (rqs_set)
         srq_o <= 1'b1; // [RL7]
      else if (poll_rd)
         srq_o <= 1'b0; // [RL2]
   end
   // Output state applied once at power-on
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         out_en_o <= 1'b0;
         off_cc_o <= 1'b0;
      end else if (pon_evt) begin
         out_en_o <= (pus_q == PUS_ON_CV) || (pus_q == PUS_ON_CC); // [RL18]
         off_cc_o <= (pus_q == PUS_ON_CC) ||
                     (pus_q == PUS_OFF_CC); // [RL19]
      end
   end
   // Read mux
   logic [7:0]  poll;
   logic [31:0] rdata;
   always_comb begin
      poll           = 8'h00;
      poll[NCH-1:0]  = trouble;
      poll[POLL_RDY] = 1'b1;
      poll[POLL_ERR] = err_led_o;
      poll[POLL_RQS] = srq_o; // [RL21]
      poll[POLL_PON] = pon_bit_q;
   end

   always_comb begin
      rdata = 32'h0;
      if (adr == OFS_CTRL) begin
         rdata[CTRL_SRQ_LSB +: 2] = srq_en_q; // [RL3]
         rdata[CTRL_PON]          = pon_en_q;
         rdata[CTRL_DISP]         = disp_on_o;
         rdata[CTRL_PUS_LSB +: 2] = pus_q;
      end else if (adr == OFS_POLL) begin
         rdata[7:0] = poll;
      end else if (adr == OFS_ERR) begin
         rdata[4:0] = err_code_q;
      end else if (adr == OFS_TEST) begin
         // Prescaler must move every cycle; a stuck timer fails
         rdata[4:0] = (presc_q != presc_last_q) ? EC_NONE
                                                : TC_TIMER; // [RL16]
      end else if (adr == OFS_INFO) begin
         rdata[0] = cal_s; // [RL17]
         rdata[NCH:1] = dly_busy;
      end else if (adr == OFS_MODEL) begin
         rdata = MODEL_ID; // [RL20]
      end else if (hit(adr, OFS_FAULT, NCH)) begin
         rdata[7:0] = fault_q[chf];
      end else if (hit(adr, OFS_MASK, NCH)) begin
         rdata[7:0] = mask_q[chf];
      end else if (hit(adr, OFS_DLY, NCH)) begin
         rdata[15:0] = 16'({dly_q[chf], 2'b00});
      end else if (hit(adr, OFS_MSG, MSG_CHARS / 4)) begin
         rdata = disp_msg_o[32*chf +: 32];
      end
   end
   // Ack one cycle after the request, data with it
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req & ~wb_ack_o & ~wb_we_i)
            wb_dat_o <= rdata;
      end
   end
endmodule

// *** test/srsc_host_bfm.sv ***
// Host model: bus controller issuing classic Wishbone single cycles.
// Assumes a shared clock and a slave that acks each request once.
`timescale 1ns/1ps
module srsc_host_bfm (
   // Clock
   input  wire logic        core_clk_i,
   // Wishbone master
   output logic             wb_cyc_o,
   output logic             wb_stb_o,
   output logic             wb_we_o,
   output logic [7:0]       wb_adr_o,
   output logic [3:0]       wb_sel_o,
   output logic [31:0]      wb_dat_o,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic        wb_ack_i
);
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o  = 1'b0;
      wb_adr_o = 8'hff;
      wb_sel_o = 4'hf;
      wb_dat_o = 32'h0;
   end

   // Request held until ack is sampled; released lines show inverse
   task automatic xfer(input logic we, input logic [7:0] adr,
                       input logic [31:0] wd, output logic [31:0] rd);
      @(posedge core_clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o  <= we;
      wb_adr_o <= adr;
      wb_sel_o <= 4'hf;
      wb_dat_o <= wd;
      do @(posedge core_clk_i); while (wb_ack_i !== 1'b1);
      rd = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_adr_o <= ~adr;
      wb_dat_o <= ~wd;
   endtask
endmodule

// *** test/srsc_props.sv ***
// Checker for the service-request block, bound into srsc_top.
// Assumes one clock domain and registered one-cycle acks.
`timescale 1ns/1ps
module srsc_props
   import srsc_pkg::*;
#(
   parameter logic [31:0] MODEL_ID = 32'h0000_1234
) (
   input wire logic        core_clk_i,
   input wire logic        reset_n_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        power_fail_i,
   input wire logic        hw_err_i,
   input wire logic        nv_wr_o,
   input wire logic        nv_data_o,
   input wire logic        srq_o,
   input wire logic        err_led_o,
   input wire logic        disp_on_o,
   input wire logic        out_en_o,
   input wire logic        off_cc_o
);
   logic       acc;
   logic [1:0] en_q;
   logic [1:0] pus_q;
   assign acc = wb_cyc_i & wb_stb_i & wb_ack_o;

   // Shadow of the last control write
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         en_q  <= 2'h0;
         pus_q <= 2'h0;
      end else if (acc && wb_we_i && wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
         en_q  <= wb_dat_i[1:0];
         pus_q <= wb_dat_i[5:4];
      end
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_ctrl_wr;
      acc && wb_we_i && wb_adr_i == OFS_CTRL && wb_sel_i[0];
   endsequence
   sequence s_rd(logic [7:0] a);
      acc && !wb_we_i && wb_adr_i == a;
   endsequence

   property p_poll_clr; s_rd(OFS_POLL) |=> !srq_o; endproperty
   a_poll_clr: assert property (p_poll_clr)
      else $error("request bit kept after poll");
   property p_poll_rqs;
      s_rd(OFS_POLL) |-> wb_dat_o[POLL_RQS] == $past(srq_o) &&
         wb_dat_o[POLL_RDY];
   endproperty
   a_poll_rqs: assert property (p_poll_rqs)
      else $error("poll byte disagrees with request bit");
   property p_err_clr; s_rd(OFS_ERR) |=> !err_led_o; endproperty
   a_err_clr: assert property (p_err_clr)
      else $error("error flag kept after error read");
   property p_err_set; $rose(hw_err_i) |-> ##[1:8] err_led_o; endproperty
   a_err_set: assert property (p_err_set)
      else $error("hardware error not flagged");
   property p_err_rqs;
      $rose(hw_err_i) && en_q[1] |-> ##[1:8] srq_o;
   endproperty
   a_err_rqs: assert property (p_err_rqs)
      else $error("error did not raise a request");
   property p_disp; s_ctrl_wr |=> disp_on_o == $past(wb_dat_i[3]); endproperty
   a_disp: assert property (p_disp)
      else $error("display state not taken");
   property p_nv;
      s_ctrl_wr |=> nv_wr_o && nv_data_o == $past(wb_dat_i[2]);
   endproperty
   a_nv: assert property (p_nv)
      else $error("power-up enable not stored");
   property p_model; s_rd(OFS_MODEL) |-> wb_dat_o == MODEL_ID; endproperty
   a_model: assert property (p_model)
      else $error("model read wrong");
   property p_en; s_rd(OFS_CTRL) |-> wb_dat_o[1:0] == en_q; endproperty
   a_en: assert property (p_en)
      else $error("request enable read wrong");
   property p_pus;
      $fell(power_fail_i) |-> ##[1:8] (off_cc_o == pus_q[1] &&
         out_en_o == (pus_q == PUS_ON_CV || pus_q == PUS_ON_CC));
   endproperty
   a_pus: assert property (p_pus)
      else $error("power-on output state wrong");
endmodule

bind srsc_top srsc_props #(.MODEL_ID(MODEL_ID)) srsc_props_i (
   .core_clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .power_fail_i, .hw_err_i,
   .nv_wr_o, .nv_data_o, .srq_o, .err_led_o, .disp_on_o, .out_en_o,
   .off_cc_o);

// *** test/srsc_top_tb_top.sv ***
// Self-checking bench for the service-request block.
// Assumes the host model for bus cycles and a shortened delay tick.
`timescale 1ns/1ps
module srsc_top_tb_top
   import srsc_pkg::*;
;
   localparam logic [31:0] MID = 32'h0000_5a5a; // Arbitrary value
   logic        core_clk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, status_i, ocp_status_o, d;
   logic        wb_ack_o, power_fail_i, nv_pon_i, cal_mode_i, hw_err_i;
   logic        nv_wr_o, nv_data_o, srq_o, err_led_o, disp_on_o;
   logic        out_en_o, off_cc_o;
   logic [95:0] disp_msg_o;
   int          num_errors, num_checks;

   srsc_top #(.NCH(4), .TICK_CYC(8), .MODEL_ID(MID)) srsc_top_i (
      .core_clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .status_i, .ocp_status_o,
      .power_fail_i, .nv_pon_i, .cal_mode_i, .hw_err_i, .nv_wr_o,
      .nv_data_o, .srq_o, .err_led_o, .disp_on_o, .disp_msg_o, .out_en_o,
      .off_cc_o);
   srsc_host_bfm srsc_host_bfm_i (
      .core_clk_i(core_clk_i), .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
      .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
      .wb_dat_o(wb_dat_i), .wb_dat_i(wb_dat_o), .wb_ack_i(wb_ack_o));

   initial core_clk_i = 1'b0;
   always #25 core_clk_i = ~core_clk_i;

   task automatic tk(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask
   task automatic chk(input string n, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] x;
      srsc_host_bfm_i.xfer(1'b1, a, v, x);
      tk(1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      srsc_host_bfm_i.xfer(1'b0, a, 32'h0, v);
      tk(1);
   endtask
   task automatic rc(input string n, input logic [7:0] a,
                     input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(n, v, e);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      tk(6000);
      num_errors++;
      test_done();
   end

   initial begin
      num_errors = 0;
      num_checks = 0;
      reset_n_i = 1'b0;
      status_i = 32'h0;
      power_fail_i = 1'b0;
      nv_pon_i = 1'b1;
      cal_mode_i = 1'b1;
      hw_err_i = 1'b0;
      tk(4);
      reset_n_i <= 1'b1;
      tk(6);
      chk("srq", 32'(srq_o), 32'h1);
      rc("poll", OFS_POLL, 32'hd0);
      chk("srq", 32'(srq_o), 32'h0);
      rc("ctrl", OFS_CTRL, 32'h0c);
      rc("dly3", OFS_DLY + 8'hc, 32'd20);
      rc("test", OFS_TEST, 32'h0);
      rc("model", OFS_MODEL, MID);
      rc("unmapped", 8'h7c, 32'h0);
      rd(OFS_INFO, d);
      chk("cal", d & 32'h1, 32'h1);
      wr(OFS_CMD, 32'h10);
      for (int e = 0; e < 4; e++) begin
         wr(OFS_CTRL, 32'h0c | 32'(e));
         rc("ctrl", OFS_CTRL, 32'h0c | 32'(e));
      end
      $display("power-on and enable test done");
      wr(OFS_CTRL, 32'h0d);
      wr(OFS_MASK + 8'h4, 32'h08);
      status_i[11] <= 1'b1;
      tk(8);
      chk("srq", 32'(srq_o), 32'h1);
      rc("poll", OFS_POLL, 32'h52);
      chk("srq", 32'(srq_o), 32'h0);
      rc("fault", OFS_FAULT + 8'h4, 32'h08);
      rc("fault", OFS_FAULT + 8'h4, 32'h0);
      rc("poll", OFS_POLL, 32'h10);
      wr(OFS_CTRL, 32'h0c);
      status_i[11] <= 1'b0;
      tk(4);
      status_i[11] <= 1'b1;
      hw_err_i <= 1'b1;
      tk(8);
      chk("srq", 32'(srq_o), 32'h0);
      chk("err_led", 32'(err_led_o), 32'h1);
      rc("fault", OFS_FAULT + 8'h4, 32'h08);
      rc("err", OFS_ERR, 32'h0a);
      chk("err_led", 32'(err_led_o), 32'h0);
      hw_err_i <= 1'b0;
      wr(OFS_CTRL, 32'h0e);
      hw_err_i <= 1'b1;
      tk(8);
      chk("srq", 32'(srq_o), 32'h1);
      rc("err", OFS_ERR, 32'h0a);
      rc("err", OFS_ERR, 32'h0);
      hw_err_i <= 1'b0;
      wr(OFS_DLY, 32'd32001);
      rc("err", OFS_ERR, 32'h05);
      rc("dly0", OFS_DLY, 32'd20);
      rd(OFS_POLL, d);
      $display("fault and error test done");
      wr(OFS_DLY + 8'h8, 32'd13);
      rc("dly2", OFS_DLY + 8'h8, 32'd12);
      wr(OFS_DLY + 8'h8, 32'd14);
      rc("dly2", OFS_DLY + 8'h8, 32'd16);
      wr(OFS_MASK + 8'h8, 32'h01);
      wr(OFS_CMD, 32'h04);
      status_i[16] <= 1'b1;
      tk(4);
      chk("ocp", 32'(ocp_status_o[16]), 32'h0);
      rc("fault2", OFS_FAULT + 8'h8, 32'h0);
      rd(OFS_INFO, d);
      chk("busy", d & 32'h8, 32'h8);
      tk(60);
      chk("ocp", 32'(ocp_status_o[16]), 32'h1);
      rd(OFS_INFO, d);
      chk("busy", d & 32'h8, 32'h0);
      $display("delay test done");
      wr(OFS_CTRL, 32'h06);
      chk("disp", 32'(disp_on_o), 32'h0);
      wr(OFS_CTRL, 32'h0e);
      chk("disp", 32'(disp_on_o), 32'h1);
      wr(OFS_MSG, 32'h2d634241);
      chk("msg", disp_msg_o[31:0], 32'h20204241);
      wr(OFS_MLEN, 32'd13);
      rc("err", OFS_ERR, 32'h07);
      rd(OFS_POLL, d);
      $display("display test done");
      for (int p = 0; p < 4; p++) begin
         wr(OFS_CTRL, 32'(p << 4) | 32'h08 | 32'((p % 2) << 2));
         power_fail_i <= 1'b1;
         tk(4);
         power_fail_i <= 1'b0;
         tk(8);
         chk("out_en", 32'(out_en_o), 32'(p == 1 || p == 2));
         chk("off_cc", 32'(off_cc_o), 32'(p >= 2));
         chk("srq", 32'(srq_o), 32'(p % 2));
         rd(OFS_POLL, d);
      end
      $display("power-up state test done");
      test_done();
   end
endmodule
